// ---- src/spimsp_top.sv ----
// Serial peripheral port, master or slave, with Avalon-MM register access
`timescale 1ns/1ps
`include "spimsp_defs.svh"
module spimsp_top
  import spimsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_b_in,
  output logic ss_b_out,
  output logic ss_oe,
  output logic pins_owned_r
);
  // ****************************************
  // Registers and state
  // ****************************************
  logic [`SPIMSP_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [`SPIMSP_RATE_W-1:0] rate_r, rate_nxt;
  logic [7:0] txbuf_r, txbuf_nxt, rxbuf_r, rxbuf_nxt, shift_r, shift_nxt;
  logic txfull_r, txfull_nxt, rxfull_r, rxfull_nxt, modf_r, modf_nxt, ovr_r, ovr_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic [2:0] pre_r, pre_nxt;
  logic [7:0] div_r, div_nxt;
  logic samp_r, samp_nxt;
  spimsp_state_e st_r, st_nxt;
  logic sck_o_r, sck_o_nxt, dout_r, dout_nxt;
  logic [1:0] sck_s_r, ss_s_r, sdi_s_r;
  logic sck_prev_r, sck_prev_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [7:0] mosi_oe_r;

  wire en = ctrl_r[`SPIMSP_B_EN];
  wire mstr = ctrl_r[`SPIMSP_B_MSTR];
  wire bidir = ctrl_r[`SPIMSP_B_BIDIR];
  wire boe = ctrl_r[`SPIMSP_B_BOE];
  wire mode_fault_enable = ctrl_r[`SPIMSP_B_MODE_FAULT_ENABLE];
  wire select_output_enable = ctrl_r[`SPIMSP_B_SELECT_OUTPUT_ENABLE];
  wire lsbf = ctrl_r[`SPIMSP_B_LSBF];
  wire cpol = ctrl_r[`SPIMSP_B_CPOL];
  wire cpha = ctrl_r[`SPIMSP_B_CPHA];
  wire bus_req = avs_read | avs_write;
  // Write lands at the edge where the master sees waitrequest low
  wire wr_hit = avs_write & ack_r;
  wire rd_hit = avs_read & ~ack_r;
  wire [7:0] rate_lim = 8'h01 << rate_r[5:3];
  wire out_bit = lsbf ? shift_r[0] : shift_r[7];
  // Fault input is a master-only role of the select pin
  wire fault_in = mstr & mode_fault_enable & ~select_output_enable & (ss_s_r[1] == 1'b0);
  // Slave edges come from the synchronised pin; four bus clocks per bit minimum
  wire sck_pin = sck_s_r[1] ^ cpol;
  wire sck_rise = sck_pin & ~sck_prev_r;
  wire sck_fall = ~sck_pin & sck_prev_r;
  wire sdi = sdi_s_r[1];
  // master samples the pin directly, so half the bus clock still works
  wire mdi = bidir ? mosi_in : miso_in;
  wire slv_sel = ~mstr & ~ss_s_r[1];

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sck_s_r <= 2'h0;
      ss_s_r <= 2'h3;
      sdi_s_r <= 2'h0;
    end
    else if (clk_en)
    begin
      sck_s_r <= {sck_s_r[0], sck_in};
      ss_s_r <= {ss_s_r[0], ss_b_in};
      sdi_s_r <= {sdi_s_r[0], mstr ? (bidir ? mosi_in : miso_in) : (bidir ? miso_in : mosi_in)};
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    rate_nxt = rate_r;
    txbuf_nxt = txbuf_r;
    txfull_nxt = txfull_r;
    rxbuf_nxt = rxbuf_r;
    rxfull_nxt = rxfull_r;
    modf_nxt = modf_r;
    ovr_nxt = ovr_r;
    shift_nxt = shift_r;
    bitcnt_nxt = bitcnt_r;
    pre_nxt = pre_r;
    div_nxt = div_r;
    samp_nxt = samp_r;
    st_nxt = st_r;
    sck_o_nxt = sck_o_r;
    dout_nxt = dout_r;
    sck_prev_nxt = sck_pin;
    ack_nxt = bus_req & ~ack_r;
    rd_nxt = 32'h0;
    if (rd_hit)
    begin
      case (avs_address)
        `SPIMSP_OFS_CTRL: rd_nxt = {23'h0, ctrl_r};
        `SPIMSP_OFS_RATE: rd_nxt = {26'h0, rate_r};
        `SPIMSP_OFS_STAT: rd_nxt = {27'h0, st_r != SPIMSP_IDLE, ovr_r, modf_r, ~txfull_r,
                                    rxfull_r};
        `SPIMSP_OFS_DATA: rd_nxt = {24'h0, rxbuf_r};
        default: rd_nxt = 32'h0;
      endcase
      if (avs_address == `SPIMSP_OFS_DATA)
        rxfull_nxt = 1'b0;
      if (avs_address == `SPIMSP_OFS_STAT)
      begin
        modf_nxt = 1'b0;
        ovr_nxt = 1'b0;
      end
    end
    if (wr_hit)
    begin
      case (avs_address)
        `SPIMSP_OFS_CTRL: ctrl_nxt = avs_writedata[`SPIMSP_CTRL_W-1:0];
        `SPIMSP_OFS_RATE: rate_nxt = avs_writedata[`SPIMSP_RATE_W-1:0];
        `SPIMSP_OFS_DATA:
        begin
          txbuf_nxt = avs_writedata[7:0];
          txfull_nxt = 1'b1;
        end
        default: ;
      endcase
    end
    // prescaler then power-of-two divider; half period is one rate tick
    if (pre_r == rate_r[2:0])
    begin
      pre_nxt = 3'h0;
      div_nxt = (div_r + 8'h01 >= rate_lim) ? 8'h00 : div_r + 8'h01;
    end
    else
      pre_nxt = pre_r + 3'h1;
    samp_nxt = (pre_r == rate_r[2:0]) && (div_r + 8'h01 >= rate_lim);
    case (st_r)
      SPIMSP_IDLE:
      begin
        bitcnt_nxt = 4'h0;
        sck_o_nxt = 1'b0;
        if (en & mstr & txfull_r & ~modf_r & samp_r)
        begin
          shift_nxt = txbuf_r;
          txfull_nxt = 1'b0;
          dout_nxt = lsbf ? txbuf_r[0] : txbuf_r[7];
          st_nxt = cpha ? SPIMSP_TRAIL : SPIMSP_LEAD;
          sck_o_nxt = cpha;
        end
        else if (en & slv_sel)
        begin
          shift_nxt = txfull_r ? txbuf_r : shift_r;
          txfull_nxt = 1'b0;
          dout_nxt = lsbf ? (txfull_r ? txbuf_r[0] : shift_r[0]) :
                            (txfull_r ? txbuf_r[7] : shift_r[7]);
          st_nxt = SPIMSP_LEAD;
        end
      end
      SPIMSP_LEAD, SPIMSP_TRAIL:
      begin
        if (mstr)
        begin
          if (samp_r)
          begin
            sck_o_nxt = ~sck_o_r;
            // sample on the leading edge when cpha is 0, on the trailing edge when cpha is 1; shift on the other
            if ((st_r == SPIMSP_LEAD) ^ cpha)
            begin
              shift_nxt = lsbf ? {mdi, shift_r[7:1]} : {shift_r[6:0], mdi};
              bitcnt_nxt = bitcnt_r + 4'h1;
            end
            else
              dout_nxt = out_bit;
            st_nxt = (st_r == SPIMSP_LEAD) ? SPIMSP_TRAIL : SPIMSP_LEAD;
          end
        end
        else if (ss_s_r[1])
          st_nxt = SPIMSP_IDLE;
        else
        begin
          if ((cpha ? sck_fall : sck_rise))
          begin
            shift_nxt = lsbf ? {sdi, shift_r[7:1]} : {shift_r[6:0], sdi};
            bitcnt_nxt = bitcnt_r + 4'h1;
          end
          if ((cpha ? sck_rise : sck_fall) || (cpha && sck_rise))
            dout_nxt = out_bit;
        end
        if (bitcnt_r == `SPIMSP_BITS)
        begin
          if (rxfull_r)
            ovr_nxt = 1'b1;
          else
          begin
            rxbuf_nxt = shift_r;
            rxfull_nxt = 1'b1;
          end
          bitcnt_nxt = 4'h0;
          sck_o_nxt = 1'b0;
          st_nxt = mstr ? SPIMSP_IDLE : SPIMSP_LEAD;
          dout_nxt = lsbf ? shift_r[0] : shift_r[7];
          if (!mstr && txfull_r)
          begin
            shift_nxt = txbuf_r;
            txfull_nxt = 1'b0;
            dout_nxt = lsbf ? txbuf_r[0] : txbuf_r[7];
          end
        end
      end
      default: st_nxt = SPIMSP_IDLE;
    endcase
    if (en & fault_in)
    begin
      modf_nxt = 1'b1;
      ctrl_nxt[`SPIMSP_B_MSTR] = 1'b0;
      st_nxt = SPIMSP_IDLE;
    end
    if (!en)
    begin
      st_nxt = SPIMSP_IDLE;
      txfull_nxt = wr_hit && avs_address == `SPIMSP_OFS_DATA;
      rxfull_nxt = 1'b0;
      bitcnt_nxt = 4'h0;
      sck_o_nxt = 1'b0;
    end
    if (rd_hit && avs_address == `SPIMSP_OFS_DATA && rxfull_nxt && !rxfull_r)
      rxfull_nxt = 1'b1;
  end

  // ****************************************
  // State registers
  // ****************************************
  // stop states gate clk_en low; deep stop asserts rst_b
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r <= `SPIMSP_CTRL_RST;
      rate_r <= `SPIMSP_RATE_RST;
      txbuf_r <= 8'h00;
      rxbuf_r <= 8'h00;
      shift_r <= 8'h00;
      txfull_r <= 1'b0;
      rxfull_r <= 1'b0;
      modf_r <= 1'b0;
      ovr_r <= 1'b0;
      bitcnt_r <= 4'h0;
      pre_r <= 3'h0;
      div_r <= 8'h00;
      samp_r <= 1'b0;
      st_r <= SPIMSP_IDLE;
      sck_o_r <= 1'b0;
      dout_r <= 1'b0;
      sck_prev_r <= 1'b0;
      ack_r <= 1'b0;
      rd_r <= 32'h0;
    end
    else if (clk_en)
    begin
      ctrl_r <= ctrl_nxt;
      rate_r <= rate_nxt;
      txbuf_r <= txbuf_nxt;
      rxbuf_r <= rxbuf_nxt;
      shift_r <= shift_nxt;
      txfull_r <= txfull_nxt;
      rxfull_r <= rxfull_nxt;
      modf_r <= modf_nxt;
      ovr_r <= ovr_nxt;
      bitcnt_r <= bitcnt_nxt;
      pre_r <= pre_nxt;
      div_r <= div_nxt;
      samp_r <= samp_nxt;
      st_r <= st_nxt;
      sck_o_r <= sck_o_nxt;
      dout_r <= dout_nxt;
      sck_prev_r <= sck_prev_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
    end
  end

  // ****************************************
  // Pin routing, all registered
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      ss_b_out <= 1'b1;
      ss_oe <= 1'b0;
      pins_owned_r <= 1'b0;
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
    end
    else if (clk_en)
    begin
      // Answer one cycle after the request is seen
      avs_waitrequest <= ~(bus_req & ~ack_r) | ack_nxt == 1'b0;
      avs_readdata <= rd_nxt;
      sck_out <= sck_o_nxt ^ ctrl_nxt[`SPIMSP_B_CPOL];
      sck_oe <= ctrl_nxt[`SPIMSP_B_EN] & ctrl_nxt[`SPIMSP_B_MSTR];
      mosi_out <= dout_nxt;
      miso_out <= dout_nxt;
      mosi_oe <= ctrl_nxt[`SPIMSP_B_EN] & ctrl_nxt[`SPIMSP_B_MSTR] &
                 (~ctrl_nxt[`SPIMSP_B_BIDIR] | ctrl_nxt[`SPIMSP_B_BOE]);
      miso_oe <= ctrl_nxt[`SPIMSP_B_EN] & ~ctrl_nxt[`SPIMSP_B_MSTR] & ~ss_s_r[1] &
                 (~ctrl_nxt[`SPIMSP_B_BIDIR] | ctrl_nxt[`SPIMSP_B_BOE]);
      ss_oe <= ctrl_nxt[`SPIMSP_B_EN] & ctrl_nxt[`SPIMSP_B_MSTR] &
               ctrl_nxt[`SPIMSP_B_MODE_FAULT_ENABLE] & ctrl_nxt[`SPIMSP_B_SELECT_OUTPUT_ENABLE];
      ss_b_out <= st_nxt == SPIMSP_IDLE;
      // pins belong to the port while enabled
      pins_owned_r <= ctrl_nxt[`SPIMSP_B_EN];
    end
  end
endmodule

// ---- src/spimsp_defs.svh ----
// Register offsets, field positions, reset values and timing counts for the serial port
`ifndef SPIMSP_DEFS_SVH
`define SPIMSP_DEFS_SVH
`define SPIMSP_OFS_CTRL 3'h0
`define SPIMSP_OFS_RATE 3'h1
`define SPIMSP_OFS_STAT 3'h2
`define SPIMSP_OFS_DATA 3'h3
`define SPIMSP_B_EN 0
`define SPIMSP_B_MSTR 1
`define SPIMSP_B_BIDIR 2
`define SPIMSP_B_BOE 3
`define SPIMSP_B_MODE_FAULT_ENABLE 4
`define SPIMSP_B_SELECT_OUTPUT_ENABLE 5
`define SPIMSP_B_LSBF 6
`define SPIMSP_B_CPOL 7
`define SPIMSP_B_CPHA 8
`define SPIMSP_CTRL_RST 9'h000
`define SPIMSP_RATE_RST 6'h00
`define SPIMSP_RATE_W 6
`define SPIMSP_CTRL_W 9
`define SPIMSP_BITS 4'h8
`define SPIMSP_SLV_SYNC 2
`endif

// ---- src/spimsp_pkg.sv ----
// Types shared by the serial port design
package spimsp_pkg;
  typedef enum logic [1:0] {SPIMSP_IDLE, SPIMSP_LEAD, SPIMSP_TRAIL} spimsp_state_e;
endpackage

// ---- verification/spimsp_sva.sv ----
// Concurrent checks on the serial port bus answer and pin drive
`timescale 1ns/1ps
module spimsp_sva (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_oe,
  input wire logic pins_owned_r
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  wire any_oe = sck_oe || mosi_oe || miso_oe || ss_oe;
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest && clk_en;
  endsequence
  sequence s_ack;
    !avs_waitrequest && clk_en;
  endsequence
  a_ack_next: assert property (s_taken |=> !avs_waitrequest)
    else $error("bus answer missing");
  a_ack_single: assert property (s_ack |=> avs_waitrequest)
    else $error("bus answer too long");
  a_ack_caused: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
    else $error("bus answer without request");
  a_unmapped_zero: assert property (!avs_waitrequest && $past(avs_read)
    && $past(avs_address) > 3'h3 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_off_release: assert property (!pins_owned_r && !$past(pins_owned_r)
    && !$past(pins_owned_r, 2) |-> !any_oe)
    else $error("pin driven while disabled");
  a_oe_owned: assert property (any_oe |-> pins_owned_r || $past(pins_owned_r))
    else $error("pin driven without ownership");
  a_data_dir: assert property (!(mosi_oe && miso_oe))
    else $error("both data pins driven");
  a_sck_master: assert property (sck_oe |-> !miso_oe)
    else $error("clock driven with slave data out");
  a_ss_master: assert property (ss_oe |-> !miso_oe)
    else $error("select driven in slave mode");
  a_stop_freeze: assert property (!clk_en |=> $stable(sck_out) && $stable(any_oe)
    && $stable(avs_waitrequest))
    else $error("state moved while stopped");
endmodule
bind spimsp_top spimsp_sva spimsp_sva_inst (.sys_clk(sys_clk), .rst_b(rst_b),
  .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sck_out(sck_out),
  .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_oe(ss_oe),
  .pins_owned_r(pins_owned_r));

// ---- verification/spimsp_partner.sv ----
// External slave device on the far side of the serial link, clock mode 0
`timescale 1ns/1ps
module spimsp_partner (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_b,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] sr;
  always @(negedge sel_b) sr = tx_byte;
  always @(posedge sck) if (!sel_b) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck) if (!sel_b) sr = {sr[6:0], 1'b0};
  // Released line flips so a stale bit never reads as good
  assign miso = sel_b ? ~sr[7] : sr[7];
endmodule

// ---- verification/test_spi_master_slave_port.sv ----
// Self-checking bench for the serial port against an external slave model
`timescale 1ns/1ps
`include "spimsp_defs.svh"
module test_spi_master_slave_port;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic ss_b_out, ss_oe, pins_owned_r, far_miso;
  logic tb_sck = 1'b0;
  logic tb_mosi = 1'b0;
  logic tb_ss_b = 1'b1;
  logic sck_q = 1'b0;
  logic [7:0] far_tx = 8'h00;
  logic [7:0] far_rx;
  int failures = 0;
  int n_compared = 0;
  int gap = 0;
  int per = 0;
  wire sck_w = sck_oe ? sck_out : tb_sck;
  wire mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire miso_w = miso_oe ? miso_out : far_miso;
  wire ss_w = ss_oe ? ss_b_out : tb_ss_b;
  spimsp_top spimsp_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_b_in(ss_w), .ss_b_out(ss_b_out),
    .ss_oe(ss_oe), .pins_owned_r(pins_owned_r));
  spimsp_partner spimsp_partner_inst (.sck(sck_w), .mosi(mosi_w),
    .sel_b(ss_oe ? ss_b_out : 1'b1), .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Bus clocks between rising serial clock edges
  always @(posedge sys_clk)
  begin
    sck_q <= sck_out;
    gap <= (sck_out && !sck_q) ? 1 : gap + 1;
    if (sck_out && !sck_q)
      per <= gap;
  end
  function int exp_period(input int p, input int r);
    return (p + 1) << (r + 1);
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task bus(input logic [2:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 1000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 1000)
      failures++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task settle;
    repeat (4) @(negedge sys_clk);
  endtask
  task wait_rx;
    logic [31:0] s;
    s = 32'h0;
    for (int n = 0; n < 9000 && s[0] !== 1'b1; n++)
      bus(`SPIMSP_OFS_STAT, 1'b0, 32'h0, s);
    check(s[0], 1'b1);
  endtask
  // Mode 0 master, slow enough for the slave's pin synchronisers
  task spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      tb_mosi <= tx[i];
      repeat (6) @(posedge sys_clk);
      tb_sck <= 1'b1;
      rx[i] = miso_w;
      repeat (6) @(posedge sys_clk);
      tb_sck <= 1'b0;
    end
  endtask
  // ****
  // Stimulus
  // ****
  initial
  begin
    logic [31:0] q;
    logic [7:0] b, rxb;
    int p, r;
    q = $urandom(32'h88532681);
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    settle;
    check({pins_owned_r, sck_oe, mosi_oe, miso_oe, ss_oe}, 5'h0);
    bus(`SPIMSP_OFS_CTRL, 1'b0, 32'h0, q);
    check(q, `SPIMSP_CTRL_RST);
    bus(`SPIMSP_OFS_RATE, 1'b0, 32'h0, q);
    check(q, `SPIMSP_RATE_RST);
    wr(3'h6, $urandom);
    bus(3'h6, 1'b0, 32'h0, q);
    check(q, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      p = (i < 2) ? 7 * i : $urandom_range(7, 0);
      r = (i < 2) ? 7 * i : $urandom_range(2, 0);
      b = 8'($urandom);
      far_tx = 8'($urandom);
      wr(`SPIMSP_OFS_CTRL, 32'h0);
      wr(`SPIMSP_OFS_RATE, {r[2:0], p[2:0]});
      wr(`SPIMSP_OFS_CTRL, 32'h33);
      wr(`SPIMSP_OFS_DATA, b);
      if (i == 1)
      begin
        repeat (100) @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (50) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
      wait_rx;
      bus(`SPIMSP_OFS_DATA, 1'b0, 32'h0, q);
      check(q[7:0], far_tx);
      check(far_rx, b);
      check(per, exp_period(p, r));
    end
    b = 8'($urandom);
    far_tx = 8'($urandom);
    wr(`SPIMSP_OFS_CTRL, 32'h1);
    wr(`SPIMSP_OFS_DATA, b);
    tb_ss_b <= 1'b0;
    repeat (8) @(posedge sys_clk);
    spi_byte(far_tx, rxb);
    repeat (8) @(posedge sys_clk);
    tb_ss_b <= 1'b1;
    check(rxb, b);
    wait_rx;
    bus(`SPIMSP_OFS_DATA, 1'b0, 32'h0, q);
    check(q[7:0], far_tx);
    spi_byte(8'h5a, rxb);
    repeat (8) @(posedge sys_clk);
    bus(`SPIMSP_OFS_STAT, 1'b0, 32'h0, q);
    check(q[0], 1'b0);
    wr(`SPIMSP_OFS_CTRL, 32'h0f);
    settle;
    check(miso_oe, 1'b0);
    wr(`SPIMSP_OFS_CTRL, 32'h07);
    settle;
    check(mosi_oe, 1'b0);
    wr(`SPIMSP_OFS_CTRL, 32'h0d);
    tb_ss_b <= 1'b0;
    settle;
    check({mosi_oe, miso_oe}, 2'b01);
    wr(`SPIMSP_OFS_CTRL, 32'h05);
    settle;
    check(miso_oe, 1'b0);
    wr(`SPIMSP_OFS_CTRL, 32'h23);
    settle;
    check(ss_oe, 1'b0);
    bus(`SPIMSP_OFS_STAT, 1'b0, 32'h0, q);
    check(q[2], 1'b0);
    wr(`SPIMSP_OFS_CTRL, 32'h13);
    settle;
    check(sck_oe, 1'b0);
    bus(`SPIMSP_OFS_STAT, 1'b0, 32'h0, q);
    check(q[2], 1'b1);
    bus(`SPIMSP_OFS_CTRL, 1'b0, 32'h0, q);
    check(q, 32'h11);
    tb_ss_b <= 1'b1;
    wr(`SPIMSP_OFS_CTRL, 32'h0);
    settle;
    check({pins_owned_r, sck_oe, mosi_oe, miso_oe, ss_oe}, 5'h0);
    wr(`SPIMSP_OFS_CTRL, 32'h33);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    bus(`SPIMSP_OFS_CTRL, 1'b0, 32'h0, q);
    check(q, `SPIMSP_CTRL_RST);
    stop_test;
  end
  // Run needs about 20k cycles; cut off at 100k
  initial
  begin
    #500000;
    failures++;
    stop_test;
  end
endmodule
